// >>> inc/sdsb_consts.vh
`ifndef SDSB_CONSTS_VH
`define SDSB_CONSTS_VH

// ----------------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------------
`define SDSB_ADDR_W           4
`define SDSB_DATA_W           16
`define SDSB_REG_CTRL         4'h0
`define SDSB_REG_OFL_STAT     4'h1
`define SDSB_REG_ST_STAT      4'h2
`define SDSB_REG_OFL_TIME     4'h3
`define SDSB_REG_FAIL_CKPT    4'h4
`define SDSB_REG_SHORT_TIME   4'h5
`define SDSB_REG_EXT_TIME     4'h6
`define SDSB_REG_RAW          4'h7
`define SDSB_REG_STATUS       4'h8
`define SDSB_CTRL_AUTO_BIT    0
`define SDSB_RAW_SLOT_LSB     8

// ----------------------------------------------------------------------------
// Sector selection
// ----------------------------------------------------------------------------
`define SDSB_SEL_ATTR         2'h0
`define SDSB_SEL_THR          2'h1
`define SDSB_SEL_LOGDIR       2'h2

// ----------------------------------------------------------------------------
// Byte offsets within a sector
// ----------------------------------------------------------------------------
`define SDSB_OFF_FIRST        9'h000
`define SDSB_OFF_REV_HI       9'h001
`define SDSB_OFF_ENTRY_FIRST  9'h002
`define SDSB_OFF_ENTRY_END    9'h16A
`define SDSB_OFF_OFL_STAT     9'h16A
`define SDSB_OFF_ST_STAT      9'h16B
`define SDSB_OFF_OFL_TIME_LO  9'h16C
`define SDSB_OFF_OFL_TIME_HI  9'h16D
`define SDSB_OFF_OFL_CAP      9'h16F
`define SDSB_OFF_SMART_CAP_LO 9'h170
`define SDSB_OFF_SMART_CAP_HI 9'h171
`define SDSB_OFF_ERRLOG_CAP   9'h172
`define SDSB_OFF_FAIL_CKPT    9'h173
`define SDSB_OFF_SHORT_TIME   9'h174
`define SDSB_OFF_EXT_BYTE     9'h175
`define SDSB_OFF_EXT_WORD_LO  9'h177
`define SDSB_OFF_EXT_WORD_HI  9'h178
`define SDSB_OFF_CKSUM        9'h1FF

// ----------------------------------------------------------------------------
// Entry layout
// ----------------------------------------------------------------------------
`define SDSB_SLOT_LAST        5'h1D
`define SDSB_ENT_IDX_LAST     4'hB
`define SDSB_ENT_ID           4'h0
`define SDSB_ENT_FLAGS_LO     4'h1
`define SDSB_ENT_VALUE        4'h3
`define SDSB_ENT_THR          4'h1
`define SDSB_FLAG_PREFAIL     0
`define SDSB_FLAG_ONLINE      1
`define SDSB_PREFAIL_SLOTS    5'h05

// ----------------------------------------------------------------------------
// Fixed field values
// ----------------------------------------------------------------------------
`define SDSB_REV              16'h0010
`define SDSB_REV_LO           8'h10
`define SDSB_REV_HI           8'h00
`define SDSB_OFL_CAP          8'h1B
`define SDSB_SMART_CAP        16'h0003
`define SDSB_SMART_CAP_LO     8'h03
`define SDSB_SMART_CAP_HI     8'h00
`define SDSB_ERRLOG_CAP       8'h01
`define SDSB_LOG_VER          16'h0001
`define SDSB_LOG_VER_LO       8'h01
`define SDSB_LOG_VER_HI       8'h00
`define SDSB_VLOG_FIRST       8'h80
`define SDSB_VLOG_LAST        8'h9F
`define SDSB_VLOG_LEN         8'h10
`define SDSB_EXT_SAT          8'hFF
`define SDSB_THR_PREFAIL      8'h10
`define SDSB_THR_ADVISORY     8'h00
`define SDSB_NORM_MAX         8'hFD
`define SDSB_NORM_MIN         8'h01
`define SDSB_NORM_RESET       8'hFD

// ----------------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------------
`define SDSB_OFL_NEVER        7'h00
`define SDSB_OFL_DONE         7'h02
`define SDSB_OFL_SUSPEND      7'h04
`define SDSB_OFL_ABORT_CMD    7'h05
`define SDSB_OFL_ABORT_FATAL  7'h06
`define SDSB_ST_PCT_MAX       4'h9
`define SDSB_ST_EXEC_LAST     4'h7
`define SDSB_ST_EXEC_INPROG   4'hF

`endif

// >>> logic/sdsb_normalizer.v
`include "sdsb_consts.vh"

// Maps a raw wear count onto the normalized range, higher is healthier
module sdsb_normalizer
(
  input  wire [7:0] raw,
  output reg  [7:0] norm
);

  // ----------------------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------------------
  // Saturates at the lowest legal value so the result never reads zero
  always @*
  begin
    if (raw >= (`SDSB_NORM_MAX - `SDSB_NORM_MIN))
      norm = `SDSB_NORM_MIN;                         // R21
    else
      norm = `SDSB_NORM_MAX - raw;                   // R21
  end

endmodule // sdsb_normalizer

// >>> logic/sdsb_sector_builder.v
`include "sdsb_consts.vh"

// Operation
// R1: Flag bit 0 marks prefailure versus advisory
// R2: Flag bit 1 marks online update; 6-15 zero
// R3: Offline status bit 7 shows automatic enable
// R4: Offline status bits 0-6 hold legal codes
// R5: Self-test remaining in tens, 0 to 9
// R6: Self-test bits 4-7 hold legal result codes
// R7: Two-byte offline collection time in seconds
// R8: Capability bits 0,1 mark subcommands implemented
// R9: Capability bit 2 says new command aborts
// R10: Capability bits 3,4,6 scan, self-test, selective
// R11: Capability word reads 03h, upper bits zero
// R12: Error logging byte reads bit 0 only
// R13: Last byte makes 512-byte sum zero
// R14: Threshold sector revision, thirty entries, zero tail
// R15: Threshold slots match attribute slots and identifiers
// R16: Threshold entry: identifier, threshold, ten zeros
// R17: Thresholds are constants, never host writable
// R18: Log directory: version 01h, count at 2n
// R19: Logs 80h to 9Fh report sixteen sectors
// R20: Multi-byte fields go least significant first
// R21: Raw measurements converted to normalized values
// R22: Byte reports self-test failure check point
// R23: Status and capability bytes at fixed offsets
// R24: 512 bytes ascending, one per handshake
module sdsb_sector_builder
(
  input  wire                      core_clk,
  input  wire                      arst_n,
  input  wire [`SDSB_ADDR_W-1:0]   reg_addr,
  input  wire [`SDSB_DATA_W-1:0]   reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [`SDSB_DATA_W-1:0]   reg_rdata_ff,
  input  wire                      sec_req,
  input  wire [1:0]                sec_sel,
  output wire                      sec_vld,
  input  wire                      sec_rdy,
  output reg  [7:0]                sec_data_ff,
  output wire                      sec_last
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  reg                    auto_en_ff;
  reg  [6:0]             ofl_code_ff;
  reg  [3:0]             st_pct_ff;
  reg  [3:0]             st_exec_ff;
  reg  [15:0]            ofl_time_ff;
  reg  [7:0]             fail_ckpt_ff;
  reg  [7:0]             short_time_ff;
  reg  [15:0]            ext_time_ff;
  reg                    busy_ff;
  reg  [1:0]             sel_ff;
  reg  [8:0]             off_ff;
  reg  [4:0]             slot_ff;
  reg  [3:0]             idx_ff;
  reg  [7:0]             sum_ff;
  reg  [8:0]             nxt_off;
  reg  [4:0]             nxt_slot;
  reg  [3:0]             nxt_idx;
  reg  [1:0]             cur_sel;
  reg  [7:0]             nxt_byte;
  reg  [7:0]             ent_id;
  reg  [7:0]             ent_flags;
  reg  [7:0]             ent_thr;
  reg  [7:0]             ent_norm;
  reg  [7:0]             log_num;
  reg  [7:0]             ext_byte;
  reg  [`SDSB_DATA_W-1:0] nxt_rdata;
  wire [7:0]             norm_out;
  wire [30*8-1:0]        norm_bus;
  wire                   start;
  wire                   xfer;
  wire                   raw_wr;
  wire                   ofl_code_ok;
  wire                   st_exec_ok;
  wire [3:0]             st_pct_in;

  // ----------------------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------------------
  // Requests while a sector is in flight are ignored
  assign start    = sec_req && !busy_ff;             // R24
  assign xfer     = busy_ff && sec_rdy;              // R24
  assign sec_vld  = busy_ff;
  assign sec_last = busy_ff && (off_ff == `SDSB_OFF_CKSUM);

  // ----------------------------------------------------------------------------
  // Register write qualification
  // ----------------------------------------------------------------------------
  assign raw_wr      = reg_wr && (reg_addr == `SDSB_REG_RAW);
  assign ofl_code_ok = (reg_wdata[6:0] == `SDSB_OFL_NEVER)     ||
                       (reg_wdata[6:0] == `SDSB_OFL_DONE)      ||
                       (reg_wdata[6:0] == `SDSB_OFL_SUSPEND)   ||
                       (reg_wdata[6:0] == `SDSB_OFL_ABORT_CMD) ||
                       (reg_wdata[6:0] == `SDSB_OFL_ABORT_FATAL); // R4
  assign st_exec_ok  = (reg_wdata[7:4] <= `SDSB_ST_EXEC_LAST) ||
                       (reg_wdata[7:4] == `SDSB_ST_EXEC_INPROG);  // R6
  assign st_pct_in   = (reg_wdata[3:0] > `SDSB_ST_PCT_MAX) ? `SDSB_ST_PCT_MAX
                                                          : reg_wdata[3:0]; // R5

  // ----------------------------------------------------------------------------
  // Raw to normalized conversion
  // ----------------------------------------------------------------------------
  sdsb_normalizer u_norm
  (
    .raw  (reg_wdata[7:0]),
    .norm (norm_out)
  );

  // ----------------------------------------------------------------------------
  // Normalized attribute values, one register per slot
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 30; gi = gi + 1)
    begin : g_slot
      reg [7:0] norm_ff;
      always @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          norm_ff <= `SDSB_NORM_RESET;
        else if (raw_wr && ({27'h0000000, reg_wdata[12:`SDSB_RAW_SLOT_LSB]} == gi))
          norm_ff <= norm_out;                       // R21
      end
      assign norm_bus[gi*8 +: 8] = norm_ff;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Software-visible status registers
  // ----------------------------------------------------------------------------
  // Illegal codes are dropped so the sector only ever carries legal values
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      auto_en_ff    <= 1'b0;
      ofl_code_ff   <= `SDSB_OFL_NEVER;
      st_pct_ff     <= 4'h0;
      st_exec_ff    <= 4'h0;
      ofl_time_ff   <= 16'h0000;
      fail_ckpt_ff  <= 8'h00;
      short_time_ff <= 8'h00;
      ext_time_ff   <= 16'h0000;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SDSB_REG_CTRL:
          auto_en_ff <= reg_wdata[`SDSB_CTRL_AUTO_BIT];       // R3
        `SDSB_REG_OFL_STAT:
          if (ofl_code_ok)
            ofl_code_ff <= reg_wdata[6:0];                     // R4
        `SDSB_REG_ST_STAT:
          if (st_exec_ok)
          begin
            st_pct_ff  <= st_pct_in;                           // R5
            st_exec_ff <= reg_wdata[7:4];                      // R6
          end
        `SDSB_REG_OFL_TIME:
          ofl_time_ff <= reg_wdata;                            // R7
        `SDSB_REG_FAIL_CKPT:
          fail_ckpt_ff <= reg_wdata[7:0];                      // R22
        `SDSB_REG_SHORT_TIME:
          short_time_ff <= reg_wdata[7:0];
        `SDSB_REG_EXT_TIME:
          ext_time_ff <= reg_wdata;
        default:
          auto_en_ff <= auto_en_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------------
  // Unmapped addresses read zero
  always @*
  begin
    nxt_rdata = {`SDSB_DATA_W{1'b0}};
    case (reg_addr)
      `SDSB_REG_CTRL:       nxt_rdata = {15'h0000, auto_en_ff};
      `SDSB_REG_OFL_STAT:   nxt_rdata = {9'h000, ofl_code_ff};
      `SDSB_REG_ST_STAT:    nxt_rdata = {8'h00, st_exec_ff, st_pct_ff};
      `SDSB_REG_OFL_TIME:   nxt_rdata = ofl_time_ff;
      `SDSB_REG_FAIL_CKPT:  nxt_rdata = {8'h00, fail_ckpt_ff};
      `SDSB_REG_SHORT_TIME: nxt_rdata = {8'h00, short_time_ff};
      `SDSB_REG_EXT_TIME:   nxt_rdata = ext_time_ff;
      `SDSB_REG_STATUS:     nxt_rdata = {6'h00, busy_ff, off_ff};
      default:              nxt_rdata = {`SDSB_DATA_W{1'b0}};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_ff <= {`SDSB_DATA_W{1'b0}};
    else if (reg_rd)
      reg_rdata_ff <= nxt_rdata;
    else
      reg_rdata_ff <= {`SDSB_DATA_W{1'b0}};
  end

  // ----------------------------------------------------------------------------
  // Next position in the sector
  // ----------------------------------------------------------------------------
  // Slot and index counters avoid a divide by twelve
  always @*
  begin
    cur_sel = busy_ff ? sel_ff : sec_sel;
    if (start)
    begin
      nxt_off  = `SDSB_OFF_FIRST;
      nxt_slot = 5'h00;
      nxt_idx  = 4'h0;
    end
    else
    begin
      nxt_off  = off_ff + 9'h001;                    // R24
      nxt_slot = slot_ff;
      nxt_idx  = 4'h0;
      if (off_ff >= `SDSB_OFF_ENTRY_FIRST)
      begin
        if (idx_ff == `SDSB_ENT_IDX_LAST)
          nxt_slot = slot_ff + 5'h01;
        else
          nxt_idx = idx_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Per-slot constants
  // ----------------------------------------------------------------------------
  // Identifiers and thresholds are fixed at build time and share one slot order
  always @*
  begin
    case (nxt_slot)
      5'h00: ent_id = 8'h01;
      5'h01: ent_id = 8'h02;
      5'h02: ent_id = 8'h03;
      5'h03: ent_id = 8'h04;
      5'h04: ent_id = 8'h05;
      5'h05: ent_id = 8'h07;
      5'h06: ent_id = 8'h08;
      5'h07: ent_id = 8'h09;
      5'h08: ent_id = 8'h0A;
      5'h09: ent_id = 8'h0C;
      5'h0A: ent_id = 8'hC0;
      5'h0B: ent_id = 8'hC1;
      5'h0C: ent_id = 8'hC2;
      5'h0D: ent_id = 8'hC4;
      5'h0E: ent_id = 8'hC5;
      5'h0F: ent_id = 8'hC6;
      5'h10: ent_id = 8'hC7;
      default: ent_id = 8'h00;                       // Unused slot
    endcase
    ent_flags = 8'h00;                               // R2
    ent_flags[`SDSB_FLAG_ONLINE]  = 1'b1;            // R2
    ent_flags[`SDSB_FLAG_PREFAIL] = (nxt_slot < `SDSB_PREFAIL_SLOTS); // R1
    ent_thr   = (nxt_slot < `SDSB_PREFAIL_SLOTS) ? `SDSB_THR_PREFAIL
                                                  : `SDSB_THR_ADVISORY; // R17
    ent_norm  = norm_bus[{nxt_slot, 3'b000} +: 8];
    log_num   = nxt_off[8:1];
    ext_byte  = (ext_time_ff >= {8'h00, `SDSB_EXT_SAT}) ? `SDSB_EXT_SAT
                                                        : ext_time_ff[7:0];
  end

  // ----------------------------------------------------------------------------
  // Byte generator
  // ----------------------------------------------------------------------------
  always @*
  begin
    nxt_byte = 8'h00;
    if (nxt_off == `SDSB_OFF_CKSUM)
      nxt_byte = 8'h00 - (sum_ff + sec_data_ff);     // R13
    else if (cur_sel == `SDSB_SEL_LOGDIR)
    begin
      if (nxt_off == `SDSB_OFF_FIRST)
        nxt_byte = `SDSB_LOG_VER_LO;                 // R18
      else if (nxt_off == `SDSB_OFF_REV_HI)
        nxt_byte = `SDSB_LOG_VER_HI;                 // R20
      else if (!nxt_off[0] && (log_num >= `SDSB_VLOG_FIRST) && (log_num <= `SDSB_VLOG_LAST))
        nxt_byte = `SDSB_VLOG_LEN;                   // R19
    end
    else if (nxt_off == `SDSB_OFF_FIRST)
      nxt_byte = `SDSB_REV_LO;                       // R14
    else if (nxt_off == `SDSB_OFF_REV_HI)
      nxt_byte = `SDSB_REV_HI;                       // R20
    else if (nxt_off < `SDSB_OFF_ENTRY_END)
    begin
      if (ent_id != 8'h00)
      begin
        if (nxt_idx == `SDSB_ENT_ID)
          nxt_byte = ent_id;                         // R15
        else if (cur_sel == `SDSB_SEL_THR)
          nxt_byte = (nxt_idx == `SDSB_ENT_THR) ? ent_thr : 8'h00; // R16
        else if (nxt_idx == `SDSB_ENT_FLAGS_LO)
          nxt_byte = ent_flags;                      // R1
        else if (nxt_idx == `SDSB_ENT_VALUE)
          nxt_byte = ent_norm;                       // R21
      end
    end
    else if (cur_sel == `SDSB_SEL_ATTR)
    begin
      // Status and capability area; the threshold sector tail stays zero
      case (nxt_off)
        `SDSB_OFF_OFL_STAT:     nxt_byte = {auto_en_ff, ofl_code_ff};   // R23
        `SDSB_OFF_ST_STAT:      nxt_byte = {st_exec_ff, st_pct_ff};     // R23
        `SDSB_OFF_OFL_TIME_LO:  nxt_byte = ofl_time_ff[7:0];            // R20
        `SDSB_OFF_OFL_TIME_HI:  nxt_byte = ofl_time_ff[15:8];           // R7
        `SDSB_OFF_OFL_CAP:      nxt_byte = `SDSB_OFL_CAP;               // R8 R9 R10
        `SDSB_OFF_SMART_CAP_LO: nxt_byte = `SDSB_SMART_CAP_LO;          // R11
        `SDSB_OFF_SMART_CAP_HI: nxt_byte = `SDSB_SMART_CAP_HI;          // R11
        `SDSB_OFF_ERRLOG_CAP:   nxt_byte = `SDSB_ERRLOG_CAP;            // R12
        `SDSB_OFF_FAIL_CKPT:    nxt_byte = fail_ckpt_ff;                // R22
        `SDSB_OFF_SHORT_TIME:   nxt_byte = short_time_ff;
        `SDSB_OFF_EXT_BYTE:     nxt_byte = ext_byte;
        `SDSB_OFF_EXT_WORD_LO:  nxt_byte = ext_time_ff[7:0];            // R20
        `SDSB_OFF_EXT_WORD_HI:  nxt_byte = ext_time_ff[15:8];
        default:                nxt_byte = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Sector streaming state
  // ----------------------------------------------------------------------------
  // The running sum covers every byte already handed over except the checksum byte
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_ff     <= 1'b0;
      sel_ff      <= `SDSB_SEL_ATTR;
      off_ff      <= `SDSB_OFF_FIRST;
      slot_ff     <= 5'h00;
      idx_ff      <= 4'h0;
      sum_ff      <= 8'h00;
      sec_data_ff <= 8'h00;
    end
    else if (start)
    begin
      busy_ff     <= 1'b1;                           // R24
      sel_ff      <= sec_sel;
      off_ff      <= nxt_off;
      slot_ff     <= nxt_slot;
      idx_ff      <= nxt_idx;
      sum_ff      <= 8'h00;                          // R13
      sec_data_ff <= nxt_byte;
    end
    else if (xfer)
    begin
      if (off_ff == `SDSB_OFF_CKSUM)
      begin
        busy_ff     <= 1'b0;                         // R24
        sec_data_ff <= 8'h00;
      end
      else
      begin
        off_ff      <= nxt_off;                      // R24
        slot_ff     <= nxt_slot;
        idx_ff      <= nxt_idx;
        sum_ff      <= sum_ff + sec_data_ff;         // R13
        sec_data_ff <= nxt_byte;
      end
    end
  end

endmodule // sdsb_sector_builder

// >>> testbench/sdsb_chk.sv
// Watches the sector stream at the builder's ports
module sdsb_chk
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_ff,
  input wire logic        sec_req,
  input wire logic [1:0]  sec_sel,
  input wire logic        sec_vld,
  input wire logic        sec_rdy,
  input wire logic [7:0]  sec_data_ff,
  input wire logic        sec_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] cnt_ff;
  logic [7:0] sum_ff;
  wire        start = sec_req && !sec_vld;

  // Count and running sum of accepted bytes, cleared on each start
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      {cnt_ff, sum_ff} <= 17'h00000;
    else if (start)
      {cnt_ff, sum_ff} <= 17'h00000;
    else if (sec_vld && sec_rdy)
      {cnt_ff, sum_ff} <= {cnt_ff + 9'h001, sum_ff + sec_data_ff};

  // ---------------------------------------------------------------
  // Stream properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  start_ack_a: assert property (start |=> sec_vld)
    else $error("sector start not answered");
  byte_hold_a: assert property (sec_vld && !sec_rdy |=> sec_vld && $stable(sec_data_ff))
    else $error("byte changed without accept");
  stream_on_a: assert property (sec_vld && sec_rdy && !sec_last |=> sec_vld)
    else $error("stream ended early");
  last_drop_a: assert property (sec_vld && sec_rdy && sec_last |=> !sec_vld)
    else $error("stream ran past last byte");
  byte_count_a: assert property (sec_last |-> sec_vld && cnt_ff == 9'h1FF)
    else $error("last byte not at offset 1FF");
  sum_zero_a: assert property (sec_vld && sec_last |-> sum_ff + sec_data_ff == 8'h00)
    else $error("sector sum not zero");
  thr_first_a: assert property (start && sec_sel == 2'h1 |=> sec_data_ff == 8'h10)
    else $error("threshold revision byte wrong");
  dir_first_a: assert property (start && sec_sel == 2'h2 |=> sec_data_ff == 8'h01)
    else $error("directory version byte wrong");
endmodule // sdsb_chk

// >>> testbench/sdsb_host.sv
// Host side that requests one sector and takes its bytes
module sdsb_host
(
  input  wire logic       core_clk,
  input  wire logic       sec_vld,
  input  wire logic [7:0] sec_data_ff,
  input  wire logic       sec_last,
  output logic            sec_req,
  output logic [1:0]      sec_sel,
  output logic            sec_rdy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:511];
  int         n;
  int         last_n;

  // Idle host with nothing requested
  initial
  begin
    sec_req = 1'b0;
    sec_sel = 2'h3;
    sec_rdy = 1'b0;
  end

  // One sector, stalling on demand, with a refused re-request if asked
  task automatic fetch(input logic [1:0] sel, input bit slow, input bit poke);
    int t;
    t = 0;
    n = 0;
    last_n = -1;
    @(posedge core_clk);
    sec_req <= 1'b1;
    sec_sel <= sel;
    while (n < 512 && t < 3000)
    begin
      @(posedge core_clk);
      t++;
      if (sec_vld && sec_rdy)
      begin
        if (sec_last)
          last_n = n;
        mem[n] = sec_data_ff;
        n++;
      end
      sec_req <= poke && t == 4;
      sec_sel <= ~sel;
      sec_rdy <= n < 512 && (!slow || t % 3 == 0);
    end
  endtask
endmodule // sdsb_host

// >>> testbench/smart_data_sector_builder_test.sv
// Top bench: register accesses and sector reads with expected images
module smart_data_sector_builder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk;
  logic        arst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire  [15:0] reg_rdata_ff;
  wire         sec_req;
  wire  [1:0]  sec_sel;
  wire         sec_vld;
  wire         sec_rdy;
  wire  [7:0]  sec_data_ff;
  wire         sec_last;
  int          fail_count;
  int          checked;
  int          cyc;
  logic [7:0]  e [0:511];
  logic [7:0]  nv [0:16];
  logic [7:0]  st;
  logic [6:0]  oc;
  logic [7:0]  ids [0:16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A,
                              8'h0C, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC7};

  sdsb_sector_builder i_dut (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .sec_req, .sec_sel, .sec_vld, .sec_rdy, .sec_data_ff, .sec_last);
  sdsb_host i_host (.core_clk, .sec_vld, .sec_data_ff, .sec_last, .sec_req, .sec_sel, .sec_rdy);

  // Clock at 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Cuts a hung run short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk($sformatf("register %0h", a), reg_rdata_ff, exp);
  endtask

  // Expected sector image
  task automatic build(input logic [1:0] sel);
    int b;
    foreach (e[i])
      e[i] = 8'h00;
    e[0] = sel == 2'h2 ? 8'h01 : 8'h10;
    for (int s = 0; s < 17 && sel != 2'h2; s++)
    begin
      b = 2 + 12 * s;
      e[b] = ids[s];
      e[b + 1] = sel == 2'h1 ? (s < 5 ? 8'h10 : 8'h00) : (s < 5 ? 8'h03 : 8'h02);
      if (sel != 2'h1)
        e[b + 3] = nv[s];
    end
    if (sel == 2'h0)
    begin
      e[9'h16A] = {1'b1, oc};
      e[9'h16B] = st;
      e[9'h16C] = 8'h34;
      e[9'h16D] = 8'h12;
      e[9'h16F] = 8'h1B;
      e[9'h170] = 8'h03;
      e[9'h172] = 8'h01;
      e[9'h173] = 8'h5A;
      e[9'h174] = 8'h07;
      e[9'h175] = 8'hFF;
      e[9'h177] = 8'h23;
      e[9'h178] = 8'h01;
    end
    for (int k = 9'h080; k <= 9'h09F && sel == 2'h2; k++)
      e[2 * k] = 8'h10;
  endtask

  // Reads one sector and compares count, sum and bytes 0 to 510
  task automatic sector(input logic [1:0] sel, input bit slow, input bit poke);
    logic [7:0] sum;
    build(sel);
    i_host.fetch(sel, slow, poke);
    sum = 8'h00;
    for (int i = 0; i < 512; i++)
      sum += i_host.mem[i];
    chk("byte count", 16'(i_host.n), 16'h0200);
    chk("last flag", 16'(i_host.last_n), 16'h01FF);
    chk("sector sum", {8'h00, sum}, 16'h0000);
    for (int i = 0; i < 511; i++)
      chk($sformatf("byte %0h", i), {8'h00, i_host.mem[i]}, {8'h00, e[i]});
    $display("test sector %0d done", sel);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    foreach (nv[i])
      nv[i] = 8'hFD;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(4'h1, 16'h0000);
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0001);
    for (int c = 0; c < 8; c++)
    begin
      if (c inside {0, 2, 4, 5, 6})
        oc = c[6:0];
      wr(4'h1, 16'(c));
      rd(4'h1, {9'h000, oc});
    end
    for (int c = 0; c < 16; c++)
    begin
      if (c < 8 || c == 15)
        st = {c[3:0], 4'h3};
      wr(4'h2, {8'h00, c[3:0], 4'h3});
      rd(4'h2, {8'h00, st});
    end
    wr(4'h2, 16'h00FC);
    st = 8'hF9;
    rd(4'h2, 16'h00F9);
    wr(4'h3, 16'h1234);
    wr(4'h4, 16'h005A);
    wr(4'h5, 16'h0007);
    wr(4'h6, 16'h0123);
    rd(4'h3, 16'h1234);
    rd(4'h4, 16'h005A);
    rd(4'h5, 16'h0007);
    rd(4'h6, 16'h0123);
    wr(4'h7, 16'h0210);
    wr(4'h7, 16'h03FB);
    wr(4'h7, 16'h04FC);
    nv[2] = 8'hED;
    nv[3] = 8'h02;
    nv[4] = 8'h01;
    rd(4'h9, 16'h0000);
    $display("test registers done");
    sector(2'h0, 1'b1, 1'b0);
    sector(2'h1, 1'b0, 1'b1);
    sector(2'h2, 1'b0, 1'b0);
    // Spare choice carries the revision and entry area, no status area
    sector(2'h3, 1'b0, 1'b0);
    rd(4'h8, 16'h01FF);
    print_verdict();
  end
endmodule // smart_data_sector_builder_test

bind sdsb_sector_builder sdsb_chk i_chk (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_ff, .sec_req, .sec_sel, .sec_vld, .sec_rdy, .sec_data_ff, .sec_last);
